//--- rtl/gpb_top.sv
// eight-bit bidirectional port with apb register access
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "gpb_cfg.svh"
module gpb_top
    import gpb_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        soft_rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // pins
    input  wire logic [7:0]  pin_i,
    output logic [7:0]       pin_o,
    output logic [7:0]       pin_oe_n_o,
    output logic [7:0]       pullup_o,
    output logic [7:0]       schmitt_sel_o,
    // alternate functions
    output logic             ext_interrupt_pin_o,
    output logic             ext_int_edge_select_o,
    input  wire logic        prog_mode_i,
    output logic             prog_clock_pin_o,
    output logic             prog_data_pin_o,
    input  wire logic        prog_data_out_i,
    input  wire logic        prog_data_oe_i,
    output logic             port_change_flag_o
);

    // ****************************************
    // state
    // ****************************************
    logic [7:0]  pins_q;
    logic [7:0]  latch_q;
    logic [7:0]  latch_d;
    logic [7:0]  dir_q;
    logic [7:0]  dir_d;
    logic [7:0]  opt_q;
    logic [7:0]  opt_d;
    logic [7:0]  mode_q;
    logic [7:0]  mode_d;
    logic [7:0]  hyst_q;
    logic [7:0]  hyst_d;
    logic        ext_q;
    logic        pclk_q;
    logic        pdat_q;
    logic        edge_q;

    logic        rdy_q;
    logic        rdy_d;
    logic        err_q;
    logic        err_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    logic        access;
    logic        first;
    logic        commit;
    logic        wr_commit;
    logic        rd_first;
    gpb_sel_t    sel;
    logic [7:0]  rd_val;
    logic [7:0]  rmw_val;
    logic        snap;
    logic        clr_flag;
    logic        mism;
    logic        flag;

    // ****************************************
    // address decode
    // ****************************************
    always_comb begin
        unique case (paddr_i[11:2])
            `GPB_IDX_DATA:   sel = GPB_SEL_DATA;
            `GPB_IDX_OPTION: sel = GPB_SEL_OPTION;
            `GPB_IDX_DIR:    sel = GPB_SEL_DIR;
            `GPB_IDX_MODE:   sel = GPB_SEL_MODE;
            `GPB_IDX_STAT:   sel = GPB_SEL_STAT;
            `GPB_IDX_BITOP:  sel = GPB_SEL_BITOP;
            default:         sel = GPB_SEL_NONE;
        endcase
    end

    // ****************************************
    // apb handshake
    // ****************************************
    // access phase takes two cycles; data taken at the first
    // access edge, writes land at the closing edge
    always_comb begin
        access    = psel_i & penable_i;
        first     = access & ~rdy_q;
        commit    = access & rdy_q;
        wr_commit = commit & pwrite_i & (sel != GPB_SEL_NONE);
        rd_first  = first & ~pwrite_i;
        rdy_d     = first;
        err_d     = first & (sel == GPB_SEL_NONE);
        rdata_d   = rdata_q;
        if (rd_first) begin
            rdata_d = {24'h00_0000, rd_val};
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= `GPB_ZERO32;
        end else begin
            rdy_q   <= rdy_d;
            err_q   <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always_comb begin
        rd_val = `GPB_ZERO8;
        unique case (sel)
            GPB_SEL_DATA:   rd_val = pins_q;
            GPB_SEL_OPTION: rd_val = opt_q;
            GPB_SEL_DIR:    rd_val = dir_q;
            GPB_SEL_MODE:   rd_val = mode_q;
            GPB_SEL_STAT: begin
                rd_val[`GPB_STAT_FLAG] = flag;
                rd_val[`GPB_STAT_MISM] = mism;
            end
            GPB_SEL_BITOP:  rd_val = `GPB_ZERO8;
            GPB_SEL_NONE:   rd_val = `GPB_ZERO8;
            default:        rd_val = `GPB_ZERO8;
        endcase
    end

    // ****************************************
    // pin sampling
    // ****************************************
    // pins are sampled every cycle; a read returns the level
    // taken before the access, so a read straight after a
    // write may still see the old level
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pins_q <= `GPB_ZERO8;
        end else begin
            pins_q <= pin_i;
        end
    end

    // ****************************************
    // read-modify-write and register writes
    // ****************************************
    always_comb begin
        // bit set/clear starts from all eight pin levels, so
        // input bits take the level seen on their pins
        rmw_val = pins_q;
        rmw_val[pwdata_i[`GPB_BITOP_MSB:0]] =
            pwdata_i[`GPB_BITOP_VAL];
    end

    always_comb begin
        latch_d = latch_q;
        dir_d   = dir_q;
        opt_d   = opt_q;
        mode_d  = mode_q;
        if (soft_rst_i) begin
            dir_d  = `GPB_DIR_RST;
            opt_d  = `GPB_OPT_RST;
            mode_d = `GPB_MODE_RST;
        end else if (wr_commit) begin
            unique case (sel)
                GPB_SEL_DATA:   latch_d = pwdata_i[7:0];
                GPB_SEL_BITOP:  latch_d = rmw_val;
                GPB_SEL_DIR:    dir_d   = pwdata_i[7:0];
                GPB_SEL_OPTION: opt_d   = pwdata_i[7:0];
                GPB_SEL_MODE:   mode_d  = pwdata_i[7:0];
                GPB_SEL_STAT:   latch_d = latch_q;
                GPB_SEL_NONE:   latch_d = latch_q;
                default:        latch_d = latch_q;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            latch_q <= `GPB_LATCH_RST;
            dir_q   <= `GPB_DIR_RST;
            opt_q   <= `GPB_OPT_RST;
            mode_q  <= `GPB_MODE_RST;
        end else begin
            latch_q <= latch_d;
            dir_q   <= dir_d;
            opt_q   <= opt_d;
            mode_q  <= mode_d;
        end
    end

    // ****************************************
    // change detection
    // ****************************************
    always_comb begin
        // a data read snaps at the sampling edge, a data write
        // or bit operation at its closing edge
        snap = (rd_first & (sel == GPB_SEL_DATA)) |
               (wr_commit & (sel == GPB_SEL_DATA)) |
               (wr_commit & (sel == GPB_SEL_BITOP));
        clr_flag = wr_commit & (sel == GPB_SEL_STAT) &
                   pwdata_i[`GPB_STAT_FLAG];
    end

    gpb_change u_change (
        .clock_i    (clock_i),
        .rst_i      (rst_i),
        .pins_i     (pins_q[7:`GPB_CHG_LSB]),
        .dir_in_i   (dir_q[7:`GPB_CHG_LSB]),
        .snap_i     (snap),
        .clear_i    (clr_flag),
        .mismatch_o (mism),
        .flag_o     (flag)
    );

    // ****************************************
    // pin cells
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            gpb_pin u_pin (
                .clock_i    (clock_i),
                .rst_i      (rst_i),
                .latch_i    (latch_q[gi]),
                .dir_in_i   (dir_q[gi]),
                .pu_on_i    (~opt_q[`GPB_OPT_PU_N]),
                .alt_en_i   (prog_mode_i &
                             (gi == `GPB_DAT_BIT)),
                .alt_out_i  (prog_data_out_i),
                .alt_oe_i   (prog_data_oe_i),
                .pin_o      (pin_o[gi]),
                .pin_oe_n_o (pin_oe_n_o[gi]),
                .pullup_o   (pullup_o[gi])
            );
        end
    endgenerate

    // ****************************************
    // alternate functions and input buffer select
    // ****************************************
    always_comb begin
        hyst_d = `GPB_ZERO8;
        hyst_d[`GPB_EXT_BIT] = mode_q[`GPB_MODE_EXT];
        hyst_d[`GPB_CLK_BIT] = prog_mode_i;
        hyst_d[`GPB_DAT_BIT] = prog_mode_i;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hyst_q <= `GPB_ZERO8;
            ext_q  <= 1'b0;
            pclk_q <= 1'b0;
            pdat_q <= 1'b0;
            edge_q <= 1'b1;
        end else begin
            hyst_q <= hyst_d;
            ext_q  <= pins_q[`GPB_EXT_BIT];
            pclk_q <= pins_q[`GPB_CLK_BIT];
            pdat_q <= pins_q[`GPB_DAT_BIT];
            edge_q <= opt_q[`GPB_OPT_EDGE];
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata_o              = rdata_q;
    assign pready_o              = rdy_q;
    assign pslverr_o             = err_q;
    assign schmitt_sel_o         = hyst_q;
    assign ext_interrupt_pin_o   = ext_q;
    assign ext_int_edge_select_o = edge_q;
    assign prog_clock_pin_o      = pclk_q;
    assign prog_data_pin_o       = pdat_q;
    assign port_change_flag_o    = flag;

endmodule

//--- rtl/gpb_cfg.svh
// constants for the eight-bit bidirectional port
`ifndef GPB_CFG_SVH
`define GPB_CFG_SVH
// register indices, byte address is four times the index
`define GPB_IDX_DATA   10'h006
`define GPB_IDX_OPTION 10'h081
`define GPB_IDX_DIR    10'h086
`define GPB_IDX_MODE   10'h00a
`define GPB_IDX_STAT   10'h00b
`define GPB_IDX_BITOP  10'h00c
// reset values
`define GPB_DIR_RST    8'hff
`define GPB_OPT_RST    8'hff
`define GPB_LATCH_RST  8'h00
`define GPB_MODE_RST   8'h00
`define GPB_OLD_RST    4'h0
`define GPB_ZERO8      8'h00
`define GPB_ZERO32     32'h0000_0000
// field positions
`define GPB_OPT_PU_N   7
`define GPB_OPT_EDGE   6
`define GPB_MODE_EXT   0
`define GPB_STAT_FLAG  0
`define GPB_STAT_MISM  1
`define GPB_BITOP_VAL  3
`define GPB_BITOP_MSB  2
`define GPB_EXT_BIT    0
`define GPB_CHG_LSB    4
`define GPB_CLK_BIT    6
`define GPB_DAT_BIT    7
`endif

//--- rtl/gpb_pkg.sv
// types for the eight-bit bidirectional port
package gpb_pkg;
    typedef enum logic [2:0] {
        GPB_SEL_NONE   = 3'b000,
        GPB_SEL_DATA   = 3'b001,
        GPB_SEL_OPTION = 3'b010,
        GPB_SEL_DIR    = 3'b011,
        GPB_SEL_MODE   = 3'b100,
        GPB_SEL_STAT   = 3'b101,
        GPB_SEL_BITOP  = 3'b110
    } gpb_sel_t;
endpackage

//--- rtl/gpb_pin.sv
// one pin cell: driver, enable and pull-up
`timescale 1ns/1ns
module gpb_pin (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic latch_i,
    input  wire logic dir_in_i,
    input  wire logic pu_on_i,
    input  wire logic alt_en_i,
    input  wire logic alt_out_i,
    input  wire logic alt_oe_i,
    output logic      pin_o,
    output logic      pin_oe_n_o,
    output logic      pullup_o
);
    logic pin_q;
    logic pin_d;
    logic oe_n_q;
    logic oe_n_d;
    logic pu_q;
    logic pu_d;

    always_comb begin
        if (alt_en_i) begin
            pin_d  = alt_out_i;
            oe_n_d = ~alt_oe_i;
        end else begin
            pin_d  = latch_i;
            oe_n_d = dir_in_i;
        end
        // pull-up off whenever the cell drives, alternate drive too
        pu_d = pu_on_i & oe_n_d;
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q  <= 1'b0;
            oe_n_q <= 1'b1;
            pu_q   <= 1'b0;
        end else begin
            pin_q  <= pin_d;
            oe_n_q <= oe_n_d;
            pu_q   <= pu_d;
        end
    end

    assign pin_o      = pin_q;
    assign pin_oe_n_o = oe_n_q;
    assign pullup_o   = pu_q;
endmodule

//--- rtl/gpb_change.sv
// change detection on the upper four port bits
`timescale 1ns/1ns
module gpb_change (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] pins_i,
    input  wire logic [3:0] dir_in_i,
    input  wire logic       snap_i,
    input  wire logic       clear_i,
    output logic            mismatch_o,
    output logic            flag_o
);
    logic [3:0] old_q;
    logic [3:0] old_d;
    logic       flag_q;
    logic       flag_d;
    logic       mism;

    always_comb begin
        mism  = |((pins_i ^ old_q) & dir_in_i);
        old_d = snap_i ? pins_i : old_q;
        // a live mismatch sets the flag even against a clear
        flag_d = mism | (flag_q & ~clear_i);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            old_q  <= `GPB_OLD_RST;
            flag_q <= 1'b0;
        end else begin
            old_q  <= old_d;
            flag_q <= flag_d;
        end
    end

    assign mismatch_o = mism;
    assign flag_o     = flag_q;
endmodule

//--- bench/gpb_ext_model.sv
// external circuitry model on the eight port pins
`timescale 1ns/1ns
module gpb_ext_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_n_i,
    input  wire logic [7:0] pu_i,
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_en_i,
    output logic      [7:0] level_o
);
    logic [7:0] last_q = 8'h00;
    always_ff @(posedge clock_i) begin
        last_q <= level_o;
    end
    // floating bits toggle so no stale level is read
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!oe_n_i[i])
                level_o[i] = drv_i[i];
            else if (ext_en_i[i])
                level_o[i] = ext_val_i[i];
            else if (pu_i[i])
                level_o[i] = 1'b1;
            else
                level_o[i] = ~last_q[i];
        end
    end
endmodule

//--- bench/gpb_top_properties.sv
// assertion checker for the port block
`timescale 1ns/1ns
`include "gpb_cfg.svh"
module gpb_top_properties (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        soft_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [7:0]  pin_i,
    input wire logic [7:0]  pin_o,
    input wire logic [7:0]  pin_oe_n_o,
    input wire logic [7:0]  pullup_o,
    input wire logic [7:0]  schmitt_sel_o,
    input wire logic        ext_interrupt_pin_o,
    input wire logic        prog_mode_i,
    input wire logic        prog_clock_pin_o,
    input wire logic        port_change_flag_o
);
    logic [1:0] up_q;
    logic [1:0] up_d;
    wire  [9:0] ix = paddr_i[11:2];
    wire        wr = psel_i & penable_i & pready_o & pwrite_i;
    // cycles since reset, saturating
    always_comb begin
        up_d = (up_q == 2'd3) ? up_q : up_q + 2'd1;
    end
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            up_q <= 2'd0;
        else
            up_q <= up_d;
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i || soft_rst_i);
    wait_one_a: assert property (
        psel_i && penable_i && !pready_o |=> pready_o)
        else $error("no answer after one wait state");
    err_ready_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    dir_drive_a: assert property (
        wr && ix == `GPB_IDX_DIR && !prog_mode_i
        |=> ##1 pin_oe_n_o == $past(pwdata_i[7:0], 2))
        else $error("enables do not follow direction");
    latch_drive_a: assert property (
        wr && ix == `GPB_IDX_DATA
        |=> ##1 pin_o[6:0] == $past(pwdata_i[6:0], 2))
        else $error("drive value does not follow latch");
    pull_off_a: assert property ((pullup_o & ~pin_oe_n_o) == 8'h00)
        else $error("pull-up on a driven pin");
    pull_on_a: assert property (
        wr && ix == `GPB_IDX_OPTION && !pwdata_i[7] && !prog_mode_i
        |=> ##1 pullup_o == pin_oe_n_o)
        else $error("pull-ups not enabled on inputs");
    read_pins_a: assert property (
        up_q == 2'd3 && psel_i && pready_o && !pwrite_i
        && ix == `GPB_IDX_DATA |-> prdata_o[7:0] == $past(pin_i, 2))
        else $error("data read is not the pin levels");
    ext_copy_a: assert property (
        up_q == 2'd3 |-> ext_interrupt_pin_o == $past(pin_i[0], 2))
        else $error("interrupt input does not follow pin 0");
    prog_clk_a: assert property (
        up_q == 2'd3 |-> prog_clock_pin_o == $past(pin_i[6], 2))
        else $error("programming clock does not follow pin 6");
    prog_st_a: assert property (
        prog_mode_i [*3] |-> schmitt_sel_o[7:6] == 2'b11)
        else $error("no hysteresis in programming mode");
    flag_hold_a: assert property (
        port_change_flag_o
        && !(wr && ix == `GPB_IDX_STAT && pwdata_i[0])
        |=> port_change_flag_o)
        else $error("change flag dropped without clear");
    cover property (wr && ix == `GPB_IDX_BITOP);
    cover property ($rose(port_change_flag_o));
    cover property (pslverr_o);
endmodule
bind gpb_top gpb_top_properties u_gpb_top_properties (
    .clock_i(clock_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o),
    .schmitt_sel_o(schmitt_sel_o), .prog_mode_i(prog_mode_i),
    .ext_interrupt_pin_o(ext_interrupt_pin_o),
    .prog_clock_pin_o(prog_clock_pin_o),
    .port_change_flag_o(port_change_flag_o));

//--- bench/tb_eight_bit_bidir_port_b.sv
// self-checking bench for the eight-bit port block
`timescale 1ns/1ns
`include "gpb_cfg.svh"
`define CHK(a, b) begin \
    tests_run++; \
    if ((a) !== (b)) begin \
        fails++; \
        $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
    end \
end
module tb_eight_bit_bidir_port_b;
    logic        clock_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        soft_rst_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic        prog_mode_i = 1'b0;
    logic        prog_out = 1'b0;
    logic        prog_oe = 1'b0;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_en = 8'hff;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, ext_interrupt_pin_o, edge_sel;
    logic        prog_clock_pin_o, prog_data_pin_o, port_change_flag_o;
    logic [7:0]  level, pin_o, pin_oe_n_o, pullup_o, schmitt_sel_o;
    logic [7:0]  rd;
    logic        er;
    int          fails = 0;
    int          tests_run = 0;
    always #5 clock_i = ~clock_i;
    gpb_top u_gpb_top (
        .clock_i(clock_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .pin_i(level),
        .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o),
        .schmitt_sel_o(schmitt_sel_o),
        .ext_interrupt_pin_o(ext_interrupt_pin_o),
        .ext_int_edge_select_o(edge_sel), .prog_mode_i(prog_mode_i),
        .prog_clock_pin_o(prog_clock_pin_o),
        .prog_data_pin_o(prog_data_pin_o), .prog_data_out_i(prog_out),
        .prog_data_oe_i(prog_oe),
        .port_change_flag_o(port_change_flag_o));
    gpb_ext_model u_gpb_ext_model (
        .clock_i(clock_i), .drv_i(pin_o), .oe_n_i(pin_oe_n_o),
        .pu_i(pullup_o), .ext_val_i(ext_val), .ext_en_i(ext_en),
        .level_o(level));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one transfer, left in its access phase for a back-to-back follow-up
    task automatic apb(input logic w, input logic [9:0] ix,
                       input logic [7:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {ix, 2'b00};
        pwdata_i <= {24'h000000, d};
        @(posedge clock_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            test_done();
        end
        rd = prdata_o[7:0];
        er = pslverr_o;
    endtask
    task automatic idle();
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        apb(1'b1, ix, d);
        idle();
    endtask
    task automatic rdc(input logic [9:0] ix, input logic [7:0] e);
        apb(1'b0, ix, 8'h00);
        idle();
        `CHK(rd, e)
    endtask
    initial begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        rdc(`GPB_IDX_DIR, `GPB_DIR_RST);
        rdc(`GPB_IDX_OPTION, `GPB_OPT_RST);
        `CHK(pullup_o, 8'h00)
        apb(1'b0, 10'h3ff, 8'h00);
        idle();
        `CHK(er, 1'b1)
        ext_val <= 8'h3c;
        wr(`GPB_IDX_DATA, 8'ha5);
        rdc(`GPB_IDX_DATA, 8'h3c);
        `CHK(ext_interrupt_pin_o, 1'b0)
        ext_en <= 8'h00;
        wr(`GPB_IDX_DIR, 8'h00);
        `CHK(pin_oe_n_o, 8'h00)
        rdc(`GPB_IDX_DATA, 8'ha5);
        `CHK(ext_interrupt_pin_o, 1'b1)
        apb(1'b1, `GPB_IDX_DATA, 8'h5a);
        apb(1'b0, `GPB_IDX_DATA, 8'h00);
        idle();
        `CHK(rd, 8'ha5)
        rdc(`GPB_IDX_DATA, 8'h5a);
        wr(`GPB_IDX_DIR, 8'hf0);
        wr(`GPB_IDX_OPTION, 8'h7f);
        `CHK(pullup_o, 8'hf0)
        `CHK(edge_sel, 1'b1)
        rdc(`GPB_IDX_DATA, 8'hfa);
        wr(`GPB_IDX_BITOP, 8'h08);
        wr(`GPB_IDX_BITOP, 8'h03);
        wr(`GPB_IDX_DIR, 8'h00);
        rdc(`GPB_IDX_DATA, 8'hf3);
        wr(`GPB_IDX_DIR, 8'hff);
        ext_en <= 8'hff;
        ext_val <= 8'h00;
        rdc(`GPB_IDX_DATA, 8'h00);
        wr(`GPB_IDX_STAT, 8'h01);
        `CHK(port_change_flag_o, 1'b0)
        ext_val <= 8'h04;
        repeat (4) @(posedge clock_i);
        `CHK(port_change_flag_o, 1'b0)
        ext_val <= 8'h24;
        repeat (4) @(posedge clock_i);
        `CHK(port_change_flag_o, 1'b1)
        wr(`GPB_IDX_STAT, 8'h01);
        rdc(`GPB_IDX_STAT, 8'h03);
        rdc(`GPB_IDX_DATA, 8'h24);
        wr(`GPB_IDX_STAT, 8'h01);
        `CHK(port_change_flag_o, 1'b0)
        wr(`GPB_IDX_MODE, 8'h01);
        `CHK(schmitt_sel_o, 8'h01)
        prog_mode_i <= 1'b1;
        prog_oe <= 1'b1;
        prog_out <= 1'b1;
        ext_en <= 8'h7f;
        ext_val <= 8'h40;
        repeat (4) @(posedge clock_i);
        `CHK(schmitt_sel_o, 8'hc1)
        `CHK(prog_clock_pin_o, 1'b1)
        `CHK(pin_oe_n_o[7], 1'b0)
        `CHK(prog_data_pin_o, 1'b1)
        prog_mode_i <= 1'b0;
        prog_oe <= 1'b0;
        ext_en <= 8'hff;
        wr(`GPB_IDX_DATA, 8'h96);
        soft_rst_i <= 1'b1;
        @(posedge clock_i);
        soft_rst_i <= 1'b0;
        @(posedge clock_i);
        rdc(`GPB_IDX_DIR, 8'hff);
        rdc(`GPB_IDX_MODE, 8'h00);
        ext_en <= 8'h00;
        wr(`GPB_IDX_DIR, 8'h00);
        rdc(`GPB_IDX_DATA, 8'h96);
        test_done();
    end
endmodule
